// ---- verilog/gate_pkg.sv ----
// Purpose: Shared constants and carrier types of the gate pre-driver control.
// Assumes: One 40 MHz clock, synchronous active-low reset.
// Notes: Phase index 0 is phase a, 1 is phase b, 2 is phase c.
// Behaviour
// - Stop the pump once its high side reaches battery plus regulation offset.
// - An opened pump supply switch also stops the pump.
// - Logic-supply undervoltage forces the pump supply switch open.
// - Host may open the pump supply switch by register write.
// - Relay outputs come only from the relay drive bits of the register.
// - Relay output is low while relay enable is low.
// - With relay enable high, relay output equals its drive bit.
// - Each phase drives its high and low gates from its own commands.
// - Enabled phase with at most one command high copies each command.
// - Both commands high and inhibit not disabled drives both gates low.
// - Inhibited both-high sets the error flag only when status option is high.
// - The diagnosis pin shows whether any inhibit error flag is set.
// - Inhibit disabled lets both gates go high with both commands high.
// - Inhibit-disable bits and status option live in the protect register.
// - Limit code 11 means no limiting; 00 to 10 select a limit window.
// - The limit window starts at every on or off gate transition.
// - Disabled phase holds both gates low; inhibited input may still set status.
// - Phase enables and relay enable are active high.
// - Phase c behaves like phases a and b with its own bits.
// - Error flags stay set until host writes 1 to the clear bit.
package gate_pkg;

    localparam int PHASES = 3;
    localparam int RELAYS = 3;
    localparam int ILIM_CODE_W = 2;
    localparam int ILIM_CNT_W = 8;

    localparam int CLOCK_PERIOD_PS = 25000;

    // Window lengths of the limit codes, in nanoseconds.
    localparam int ILIM_TIME0_NS = 250;
    localparam int ILIM_TIME1_NS = 500;
    localparam int ILIM_TIME2_NS = 1000;

    // Least times round up to whole cycles.
    localparam int ILIM_CYC0 =
        (ILIM_TIME0_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int ILIM_CYC1 =
        (ILIM_TIME1_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int ILIM_CYC2 =
        (ILIM_TIME2_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

    localparam logic [ILIM_CODE_W-1:0] ILIM_CODE0 = 2'h0;
    localparam logic [ILIM_CODE_W-1:0] ILIM_CODE1 = 2'h1;
    localparam logic [ILIM_CODE_W-1:0] ILIM_CODE2 = 2'h2;
    localparam logic [ILIM_CODE_W-1:0] ILIM_NONE = 2'h3;

    typedef struct packed {
        logic pump_off;
        logic [RELAYS-1:0] relay_drive;
    } pump_relay_t;

    typedef struct packed {
        logic status_option;
        logic [PHASES-1:0] inhibit_disable;
    } protect_t;

    typedef struct packed {
        logic [PHASES-1:0] high;
        logic [PHASES-1:0] low;
    } phase_cmd_t;

    localparam pump_relay_t PUMP_RELAY_RESET = '{pump_off: 1'b0,
                                                 relay_drive: 3'h0};
    localparam protect_t PROTECT_RESET = '{status_option: 1'b0,
                                           inhibit_disable: 3'h0};
    localparam logic [ILIM_CODE_W-1:0] ILIM_RESET = ILIM_NONE;

endpackage : gate_pkg

// ---- verilog/limit_window.sv ----
// Purpose: Gate-current limit window timer for one driver.
// Assumes: Trigger is a one-cycle pulse on each drive transition.
// Notes: The window output is decoded from the registered count.
`timescale 1ns/100ps
module limit_window
    import gate_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic trigger,
    input wire logic [ILIM_CODE_W-1:0] code,
    output logic active
);

    logic [ILIM_CNT_W-1:0] count_reg;
    logic [ILIM_CNT_W-1:0] load_value;

    always_comb begin
        unique case (code)
            ILIM_CODE0: load_value = ILIM_CNT_W'(ILIM_CYC0);
            ILIM_CODE1: load_value = ILIM_CNT_W'(ILIM_CYC1);
            ILIM_CODE2: load_value = ILIM_CNT_W'(ILIM_CYC2);
            default: load_value = '0;
        endcase
    end

    // A transition inside a running window restarts it.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (trigger) begin
            count_reg <= load_value;
        end else if (code == ILIM_NONE) begin
            count_reg <= '0;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign active = (count_reg != '0);

endmodule : limit_window

// ---- verilog/gate_predriver.sv ----
// Purpose: Phase gating, inhibit protection, relay drive and pump switch.
// Assumes: Command pins and analog detector levels are asynchronous;
//          enables and register write ports come from logic on CLOCK.
// Notes: All outputs are registered; command pins add three cycles.
`timescale 1ns/100ps
module gate_predriver
    import gate_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [PHASES-1:0] PHASE_HIGH_CMD,
    input wire logic [PHASES-1:0] PHASE_LOW_CMD,
    input wire logic [PHASES-1:0] PHASE_ENABLE,
    input wire logic RELAY_ENABLE,
    input wire logic LOGIC_UNDERVOLTAGE,
    input wire logic PUMP_AT_LIMIT,
    input wire logic PUMP_RELAY_WR,
    input wire pump_relay_t PUMP_RELAY_WDATA,
    input wire logic PROTECT_WR,
    input wire protect_t PROTECT_WDATA,
    input wire logic ILIM_WR,
    input wire logic [ILIM_CODE_W-1:0] ILIM_WDATA,
    input wire logic [PHASES-1:0] ERROR_CLEAR,
    output logic [PHASES-1:0] PHASE_HIGH_GATE,
    output logic [PHASES-1:0] PHASE_LOW_GATE,
    output logic [PHASES-1:0] HIGH_LIMIT,
    output logic [PHASES-1:0] LOW_LIMIT,
    output logic [RELAYS-1:0] RELAY_GATE_OUT,
    output logic PUMP_SUPPLY_SWITCH,
    output logic PUMP_RUN,
    output logic [PHASES-1:0] INHIBIT_ERROR,
    output logic DIAGNOSIS_N,
    output pump_relay_t PUMP_RELAY_Q,
    output protect_t PROTECT_Q,
    output logic [ILIM_CODE_W-1:0] ILIM_Q
);

    // Pin synchronisers: the first stage is read only by the second.
    phase_cmd_t cmd_meta_reg;
    phase_cmd_t cmd_sync_reg;
    logic uv_meta_reg;
    logic uv_sync_reg;
    logic limit_meta_reg;
    logic limit_sync_reg;

    // Register file written by the host interface logic.
    pump_relay_t pump_relay_control_reg;
    protect_t input_protect_ctrl_reg;
    logic [ILIM_CODE_W-1:0] ilim_timing_reg;

    // Drive state.
    logic [PHASES-1:0] high_gate_reg;
    logic [PHASES-1:0] low_gate_reg;
    logic [PHASES-1:0] high_gate_next;
    logic [PHASES-1:0] low_gate_next;
    logic [PHASES-1:0] inhibit_error_reg;
    logic [PHASES-1:0] inhibit_error_next;
    logic [PHASES-1:0] both_high;
    logic [PHASES-1:0] inhibit_hit;
    logic [PHASES-1:0] high_edge;
    logic [PHASES-1:0] low_edge;
    logic [PHASES-1:0] high_window;
    logic [PHASES-1:0] low_window;
    logic [PHASES-1:0] high_limit_reg;
    logic [PHASES-1:0] low_limit_reg;
    logic [RELAYS-1:0] relay_gate_reg;
    logic [RELAYS-1:0] relay_gate_next;
    logic diagnosis_n_reg;
    logic pump_supply_switch;
    logic pump_switch_next;
    logic pump_run_reg;
    logic pump_run_next;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            cmd_meta_reg <= '0;
            cmd_sync_reg <= '0;
        end else begin
            cmd_meta_reg <= '{high: PHASE_HIGH_CMD, low: PHASE_LOW_CMD};
            cmd_sync_reg <= cmd_meta_reg;
        end
    end

    // Undervoltage resets to detected so the pump starts only after a
    // clean sample of the supply.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            uv_meta_reg <= 1'b1;
            uv_sync_reg <= 1'b1;
        end else begin
            uv_meta_reg <= LOGIC_UNDERVOLTAGE;
            uv_sync_reg <= uv_meta_reg;
        end
    end

    // The limit comparator can only stop the pump, so a clear reset value
    // is safe: a real limit shows up two edges later.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            limit_meta_reg <= 1'b0;
            limit_sync_reg <= 1'b0;
        end else begin
            limit_meta_reg <= PUMP_AT_LIMIT;
            limit_sync_reg <= limit_meta_reg;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pump_relay_control_reg <= PUMP_RELAY_RESET;
        end else if (PUMP_RELAY_WR) begin
            pump_relay_control_reg <= PUMP_RELAY_WDATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            input_protect_ctrl_reg <= PROTECT_RESET;
        end else if (PROTECT_WR) begin
            input_protect_ctrl_reg <= PROTECT_WDATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ilim_timing_reg <= ILIM_RESET;
        end else if (ILIM_WR) begin
            ilim_timing_reg <= ILIM_WDATA;
        end
    end

    // Per-phase gating and inhibit detection.
    genvar p;
    generate
        for (p = 0; p < PHASES; p++) begin : g_phase
            logic hi;
            logic lo;
            logic dis;
            assign hi = cmd_sync_reg.high[p];
            assign lo = cmd_sync_reg.low[p];
            assign dis = input_protect_ctrl_reg.inhibit_disable[p];
            assign both_high[p] = hi & lo;
            // Detection runs even with the phase disabled.
            assign inhibit_hit[p] = both_high[p] & ~dis;

            always_comb begin
                if (!PHASE_ENABLE[p]) begin
                    high_gate_next[p] = 1'b0;
                    low_gate_next[p] = 1'b0;
                end else if (inhibit_hit[p]) begin
                    high_gate_next[p] = 1'b0;
                    low_gate_next[p] = 1'b0;
                end else begin
                    high_gate_next[p] = hi;
                    low_gate_next[p] = lo;
                end
            end

            // A new error wins over a clear in the same cycle.
            always_comb begin
                if (inhibit_hit[p] && input_protect_ctrl_reg.status_option) begin
                    inhibit_error_next[p] = 1'b1;
                end else if (ERROR_CLEAR[p]) begin
                    inhibit_error_next[p] = 1'b0;
                end else begin
                    inhibit_error_next[p] = inhibit_error_reg[p];
                end
            end

            assign high_edge[p] = high_gate_next[p] ^ high_gate_reg[p];
            assign low_edge[p] = low_gate_next[p] ^ low_gate_reg[p];

            limit_window u_high_window (
                .clock(CLOCK),
                .rst_n(RST_N),
                .trigger(high_edge[p]),
                .code(ilim_timing_reg),
                .active(high_window[p])
            );

            limit_window u_low_window (
                .clock(CLOCK),
                .rst_n(RST_N),
                .trigger(low_edge[p]),
                .code(ilim_timing_reg),
                .active(low_window[p])
            );
        end
    endgenerate

    // Gates are registered so that a glitch between the synchronised
    // command bits never reaches a driver.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            high_gate_reg <= '0;
            low_gate_reg <= '0;
        end else begin
            high_gate_reg <= high_gate_next;
            low_gate_reg <= low_gate_next;
        end
    end

    // The window counter loads at the edge that moves the gate, so the
    // limit output rises one cycle after the gate output changes.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            high_limit_reg <= '0;
        end else begin
            high_limit_reg <= high_window;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            low_limit_reg <= '0;
        end else begin
            low_limit_reg <= low_window;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            inhibit_error_reg <= '0;
        end else begin
            inhibit_error_reg <= inhibit_error_next;
        end
    end

    // The pin follows the next flag value so that it changes in step
    // with the flag register.
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            diagnosis_n_reg <= 1'b1;
        end else begin
            diagnosis_n_reg <= ~(|inhibit_error_next);
        end
    end

    // Relay outputs never see a pin, only the register and the enable.
    genvar r;
    generate
        for (r = 0; r < RELAYS; r++) begin : g_relay
            logic drive_bit;
            assign drive_bit = pump_relay_control_reg.relay_drive[r];
            always_comb begin
                if (RELAY_ENABLE) begin
                    relay_gate_next[r] = drive_bit;
                end else begin
                    relay_gate_next[r] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            relay_gate_reg <= '0;
        end else begin
            relay_gate_reg <= relay_gate_next;
        end
    end

    // Switch closed means the battery feeds the pump.
    always_comb begin
        pump_switch_next = 1'b1;
        if (uv_sync_reg) begin
            pump_switch_next = 1'b0;
        end
        if (pump_relay_control_reg.pump_off) begin
            pump_switch_next = 1'b0;
        end
    end

    // An open switch stops the pump as surely as the limit comparator.
    always_comb begin
        pump_run_next = pump_switch_next;
        if (limit_sync_reg) begin
            pump_run_next = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pump_supply_switch <= 1'b0;
        end else begin
            pump_supply_switch <= pump_switch_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pump_run_reg <= 1'b0;
        end else begin
            pump_run_reg <= pump_run_next;
        end
    end

    assign PHASE_HIGH_GATE = high_gate_reg;
    assign PHASE_LOW_GATE = low_gate_reg;
    assign HIGH_LIMIT = high_limit_reg;
    assign LOW_LIMIT = low_limit_reg;
    assign RELAY_GATE_OUT = relay_gate_reg;
    assign PUMP_SUPPLY_SWITCH = pump_supply_switch;
    assign PUMP_RUN = pump_run_reg;
    assign INHIBIT_ERROR = inhibit_error_reg;
    assign DIAGNOSIS_N = diagnosis_n_reg;
    assign PUMP_RELAY_Q = pump_relay_control_reg;
    assign PROTECT_Q = input_protect_ctrl_reg;
    assign ILIM_Q = ilim_timing_reg;

endmodule : gate_predriver

// ---- test/gate_predriver_asserts.sv ----
// Purpose: Port checks of the gate pre-driver control.
// Assumes: Pins reach outputs in 3 edges, registers and enables in 1.
// Notes: Bound to every gate_predriver instance.
`timescale 1ns/100ps
module gate_predriver_asserts
    import gate_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [PHASES-1:0] PHASE_ENABLE,
    input wire logic RELAY_ENABLE,
    input wire logic LOGIC_UNDERVOLTAGE,
    input wire logic PUMP_AT_LIMIT,
    input wire logic [PHASES-1:0] ERROR_CLEAR,
    input wire logic [PHASES-1:0] PHASE_HIGH_GATE,
    input wire logic [PHASES-1:0] PHASE_LOW_GATE,
    input wire logic [PHASES-1:0] HIGH_LIMIT,
    input wire logic [RELAYS-1:0] RELAY_GATE_OUT,
    input wire logic PUMP_SUPPLY_SWITCH,
    input wire logic PUMP_RUN,
    input wire logic [PHASES-1:0] INHIBIT_ERROR,
    input wire logic DIAGNOSIS_N,
    input wire pump_relay_t PUMP_RELAY_Q,
    input wire protect_t PROTECT_Q,
    input wire logic [ILIM_CODE_W-1:0] ILIM_Q
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    chk_phase_off: assert property (
        ((PHASE_HIGH_GATE | PHASE_LOW_GATE) & ~$past(PHASE_ENABLE)) == 3'h0)
        else $error("gate on in a disabled phase");
    chk_both_high: assert property (
        (PHASE_HIGH_GATE & PHASE_LOW_GATE
         & ~$past(PROTECT_Q.inhibit_disable)) == 3'h0)
        else $error("both gates on while inhibited");
    chk_relay_out: assert property (
        RELAY_GATE_OUT == ($past(PUMP_RELAY_Q.relay_drive)
                           & {RELAYS{$past(RELAY_ENABLE)}}))
        else $error("relay output wrong");
    chk_switch_off: assert property (
        PUMP_SUPPLY_SWITCH |-> !$past(PUMP_RELAY_Q.pump_off)
                               && !$past(LOGIC_UNDERVOLTAGE, 3))
        else $error("pump switch on when it must be open");
    chk_pump_stop: assert property (
        PUMP_RUN |-> PUMP_SUPPLY_SWITCH && !$past(PUMP_AT_LIMIT, 3))
        else $error("pump runs when it must stop");
    chk_diagnosis_pin_pin: assert property (
        DIAGNOSIS_N == ~(|INHIBIT_ERROR))
        else $error("diagnosis pin does not track flags");
    chk_error_hold: assert property (
        ($past(INHIBIT_ERROR) & ~INHIBIT_ERROR & ~$past(ERROR_CLEAR)) == 3'h0)
        else $error("error flag dropped without clear");
    chk_error_option: assert property (
        (INHIBIT_ERROR & ~$past(INHIBIT_ERROR)) != 3'h0
        |-> $past(PROTECT_Q.status_option))
        else $error("error flag set with status option low");
    chk_limit_window: assert property (
        $rose(PHASE_HIGH_GATE[0]) && ILIM_Q == ILIM_CODE0
        |=> HIGH_LIMIT[0] [*8])
        else $error("limit window too short");

    cover property (INHIBIT_ERROR != 3'h0);
    cover property ((PHASE_HIGH_GATE & PHASE_LOW_GATE) != 3'h0);
    cover property ($fell(PUMP_RUN));
endmodule : gate_predriver_asserts

bind gate_predriver gate_predriver_asserts i_gate_predriver_asserts (.*);

// ---- test/host_model.sv ----
// Purpose: Host controller driving commands and register writes.
// Assumes: Everything changes on the falling clock edge.
// Notes: Write strobes last exactly one cycle, as the ports take them.
`timescale 1ns/100ps
module host_model
    import gate_pkg::*;
(
    input wire logic CLOCK,
    output logic [PHASES-1:0] PHASE_HIGH_CMD,
    output logic [PHASES-1:0] PHASE_LOW_CMD,
    output logic [PHASES-1:0] PHASE_ENABLE,
    output logic RELAY_ENABLE,
    output logic PUMP_RELAY_WR,
    output pump_relay_t PUMP_RELAY_WDATA,
    output logic PROTECT_WR,
    output protect_t PROTECT_WDATA,
    output logic ILIM_WR,
    output logic [ILIM_CODE_W-1:0] ILIM_WDATA,
    output logic [PHASES-1:0] ERROR_CLEAR
);
    initial begin
        {PHASE_HIGH_CMD, PHASE_LOW_CMD, PHASE_ENABLE, RELAY_ENABLE} = '0;
        {PUMP_RELAY_WR, PROTECT_WR, ILIM_WR, ERROR_CLEAR} = '0;
        {PUMP_RELAY_WDATA, PROTECT_WDATA, ILIM_WDATA} = '0;
    end

    // Target 0 pump/relay, 1 protect, 2 limit code, 3 error clear.
    task automatic write(input int sel, input logic [3:0] d);
        @(negedge CLOCK);
        PUMP_RELAY_WDATA = pump_relay_t'(d);
        PROTECT_WDATA = protect_t'(d);
        ILIM_WDATA = d[1:0];
        PUMP_RELAY_WR = (sel == 0);
        PROTECT_WR = (sel == 1);
        ILIM_WR = (sel == 2);
        ERROR_CLEAR = (sel == 3) ? d[2:0] : 3'h0;
        @(negedge CLOCK);
        {PUMP_RELAY_WR, PROTECT_WR, ILIM_WR, ERROR_CLEAR} = '0;
    endtask : write

    task automatic drive(input logic [2:0] en, input logic [2:0] hi,
                         input logic [2:0] lo, input logic rel);
        @(negedge CLOCK);
        PHASE_ENABLE = en;
        PHASE_HIGH_CMD = hi;
        PHASE_LOW_CMD = lo;
        RELAY_ENABLE = rel;
    endtask : drive
endmodule : host_model

// ---- test/testbench.sv ----
// Purpose: Self-checking bench of the gate pre-driver control.
// Assumes: Host model drives commands and writes on the falling edge.
// Notes: Signals wired to the design keep its port names for brevity.
`timescale 1ns/100ps
module testbench
    import gate_pkg::*;
;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic LOGIC_UNDERVOLTAGE = 1'b0;
    logic PUMP_AT_LIMIT = 1'b0;
    logic [PHASES-1:0] PHASE_HIGH_CMD, PHASE_LOW_CMD, PHASE_ENABLE;
    logic [PHASES-1:0] ERROR_CLEAR, INHIBIT_ERROR, HIGH_LIMIT, LOW_LIMIT;
    logic [PHASES-1:0] PHASE_HIGH_GATE, PHASE_LOW_GATE;
    logic [RELAYS-1:0] RELAY_GATE_OUT;
    logic RELAY_ENABLE, PUMP_RELAY_WR, PROTECT_WR, ILIM_WR;
    logic PUMP_SUPPLY_SWITCH, PUMP_RUN, DIAGNOSIS_N;
    pump_relay_t PUMP_RELAY_WDATA, PUMP_RELAY_Q;
    protect_t PROTECT_WDATA, PROTECT_Q;
    logic [ILIM_CODE_W-1:0] ILIM_WDATA, ILIM_Q;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    int m;
    int cyc [4] = '{ILIM_CYC0, ILIM_CYC1, ILIM_CYC2, 0};
    logic [7:0] r;
    // Row: enable, high, low, disable, option, high gate, low gate, error.
    logic [7:0] rows [9] = '{8'h80, 8'hc4, 8'ha2, 8'he0, 8'he9,
                             8'hfe, 8'h40, 8'h69, 8'h70};

    host_model i_host_model (.*);
    gate_predriver i_gate_predriver (.*);

    always #12.5 CLOCK = ~CLOCK;

    task automatic cmp(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic results();
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // The run needs about 840 cycles; a hang is cut off well after.
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (12) @(negedge CLOCK);
        RST_N = 1'b1;
        @(negedge CLOCK);
        cmp("protect_q", PROTECT_RESET, PROTECT_Q);
        cmp("ilim_q", ILIM_RESET, ILIM_Q);
        cmp("pump_relay_q", PUMP_RELAY_RESET, PUMP_RELAY_Q);
        cmp("diagnosis_pin_n", 8'h1, DIAGNOSIS_N);
        foreach (rows[i]) begin
            r = rows[i];
            i_host_model.write(1, {r[3], {3{r[4]}}});
            i_host_model.drive({3{r[7]}}, {3{r[6]}}, {3{r[5]}}, 1'b0);
            repeat (5) @(negedge CLOCK);
            cmp("high_gate", {3{r[2]}}, PHASE_HIGH_GATE);
            cmp("low_gate", {3{r[1]}}, PHASE_LOW_GATE);
            cmp("error", {3{r[0]}}, INHIBIT_ERROR);
            i_host_model.drive(3'h0, 3'h0, 3'h0, 1'b0);
            repeat (5) @(negedge CLOCK);
            cmp("error_held", {3{r[0]}}, INHIBIT_ERROR);
            cmp("diagnosis_pin_n", 8'(!r[0]), DIAGNOSIS_N);
            i_host_model.write(3, 4'h7);
            repeat (2) @(negedge CLOCK);
            cmp("error_clr", 8'h0, INHIBIT_ERROR);
        end
        for (int e = 0; e < 2; e++) begin
            for (int d = 0; d < 8; d++) begin
                i_host_model.write(0, 4'(d));
                i_host_model.drive(3'h0, 3'h0, 3'h0, e[0]);
                repeat (3) @(negedge CLOCK);
                cmp("relay", 8'(e ? d : 0), RELAY_GATE_OUT);
                cmp("pump_relay_q", 8'(d), PUMP_RELAY_Q);
            end
        end
        for (int p = 0; p < 8; p++) begin
            i_host_model.write(0, {p[0], 3'h0});
            LOGIC_UNDERVOLTAGE = p[1];
            PUMP_AT_LIMIT = p[2];
            repeat (5) @(negedge CLOCK);
            cmp("pump_switch", 8'(p[1:0] == 0), PUMP_SUPPLY_SWITCH);
            cmp("pump_run", 8'(p[2:0] == 0), PUMP_RUN);
        end
        for (int c = 0; c < 4; c++) begin
            i_host_model.write(2, 4'(c));
            cmp("ilim_q", 8'(c), ILIM_Q);
            // Count the windows after the on and then the off transition,
            // high side on phase a and low side on phase b.
            for (int s = 1; s >= 0; s--) begin
                i_host_model.drive(3'h7, 3'(s), 3'(s * 2), 1'b0);
                n = 0;
                m = 0;
                repeat (60) begin
                    @(negedge CLOCK);
                    n += (HIGH_LIMIT[0] === 1'b1);
                    m += (LOW_LIMIT[1] === 1'b1);
                end
                cmp("limit_cycles", 8'(cyc[c]), 8'(n));
                cmp("low_limit_cycles", 8'(cyc[c]), 8'(m));
            end
        end
        i_host_model.write(1, 4'h8);
        i_host_model.drive(3'h0, 3'h7, 3'h7, 1'b1);
        repeat (5) @(negedge CLOCK);
        cmp("error_off_phase", 8'h7, INHIBIT_ERROR);
        // A clear that meets a standing inhibited input loses to the set.
        i_host_model.write(3, 4'h7);
        cmp("error_set_wins", 8'h7, INHIBIT_ERROR);
        LOGIC_UNDERVOLTAGE = 1'b0;
        PUMP_AT_LIMIT = 1'b0;
        RST_N = 1'b0;
        repeat (4) @(negedge CLOCK);
        cmp("error_reset", 8'h0, INHIBIT_ERROR);
        cmp("protect_reset", PROTECT_RESET, PROTECT_Q);
        cmp("switch_reset", 8'h0, PUMP_SUPPLY_SWITCH);
        RST_N = 1'b1;
        // The undervoltage synchroniser restarts at detected, so the
        // switch closes only on the third edge after release.
        @(negedge CLOCK);
        cmp("switch_early", 8'h0, PUMP_SUPPLY_SWITCH);
        repeat (2) @(negedge CLOCK);
        cmp("switch_closed", 8'h1, PUMP_SUPPLY_SWITCH);
        cmp("pump_running", 8'h1, PUMP_RUN);
        cmp("error_after_reset", 8'h0, INHIBIT_ERROR);
        cmp("gates_reset", 8'h0, PHASE_HIGH_GATE | PHASE_LOW_GATE);
        results();
    end
endmodule : testbench
